// >>> hw/siosm_top.sv
`timescale 1ns/1ns
// Overview of operation
// R1 - selector 0..6 picks pins 13,7..12 at first level; 9..F same, opposite level
// R2 - selector 7 forces the function on, 8 forces it off, no pin read
// R3 - option inputs four to six accept only pins 10..12 or selectors 7 and 8; others are refused
// R4 - one pin may feed several input functions at once
// R5 - output selector 1..3 picks pair 1/2, 23/24, 25/26; 0 leaves it unused
// R6 - functions sharing one output pair are ored together
// R7 - a status not evaluated in the present control mode counts as inactive
// R8 - nine status functions each have their own output selector
// R9 - per-pair invert bit flips the driven level of that pair
// R10 - pins synchronised to the clock; selectors applied from registered copies
module siosm_top
(
  // clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       rst_in,
  // connector input pins, bit 0..6 = pins 13, 7, 8, 9, 10, 11, 12
  input  wire logic [6:0] conn_in_in,
  // input function selectors
  input  wire logic [3:0] fwd_travel_sel_in,
  input  wire logic [3:0] rev_travel_sel_in,
  input  wire logic [3:0] fwd_force_sel_in,
  input  wire logic [3:0] rev_force_sel_in,
  input  wire logic [3:0] opt_in3_sel_in,
  input  wire logic [3:0] opt_in4_sel_in,
  input  wire logic [3:0] opt_in5_sel_in,
  input  wire logic [3:0] opt_in6_sel_in,
  // output function selectors and pair polarity
  input  wire logic [1:0] pos_done_sel_in,
  input  wire logic [1:0] speed_match_sel_in,
  input  wire logic [1:0] motion_sel_in,
  input  wire logic [1:0] ready_sel_in,
  input  wire logic [1:0] force_lim_out_sel_in,
  input  wire logic [1:0] speed_lim_out_sel_in,
  input  wire logic [1:0] brake_sel_in,
  input  wire logic [1:0] warning_sel_in,
  input  wire logic [1:0] near_sel_in,
  input  wire logic [2:0] output_invert_cfg_in,
  // internal status functions, active high
  input  wire logic       position_done_in,
  input  wire logic       speed_match_in,
  input  wire logic       motion_detected_in,
  input  wire logic       drive_ready_in,
  input  wire logic       force_limit_active_in,
  input  wire logic       speed_limit_active_in,
  input  wire logic       brake_release_in,
  input  wire logic       warning_in,
  input  wire logic       near_position_in,
  // per status: evaluated in the present control mode
  input  wire logic [8:0] status_eval_in,
  // input functions to the drive, active high
  output logic            fwd_travel_block_out,
  output logic            rev_travel_block_out,
  output logic            fwd_force_limit_in_out,
  output logic            rev_force_limit_in_out,
  output logic            option_input_3_out,
  output logic            option_input_4_out,
  output logic            option_input_5_out,
  output logic            option_input_6_out,
  // output pin pairs 1/2, 23/24, 25/26
  output logic [2:0]      pair_drive_out,
  // presented input selector refused
  output logic            sel_reject_out
);

  typedef struct packed {
    logic [6:0]      pin_meta;
    logic [6:0]      pin_sync;
    logic [7:0][3:0] in_sel;
    logic [8:0][1:0] out_sel;
    logic [2:0]      invert;
    logic [7:0]      func;
    logic [2:0]      pair;
    logic            reject;
  } siosm_state_t;

  siosm_state_t    state_reg;
  siosm_state_t    state_next;
  logic [7:0][3:0] in_sel_w;
  logic [8:0][1:0] out_sel_w;
  logic [8:0]      status_w;

  siosm_route_if rt ();

  siosm_out_route u_route
  (
    .rt (rt.route)
  );

  // packing order must match the function indices of the package
  assign in_sel_w = {opt_in6_sel_in,
                     opt_in5_sel_in,
                     opt_in4_sel_in,
                     opt_in3_sel_in,
                     rev_force_sel_in,
                     fwd_force_sel_in,
                     rev_travel_sel_in,
                     fwd_travel_sel_in};

  assign out_sel_w = {near_sel_in,
                      warning_sel_in,
                      brake_sel_in,
                      speed_lim_out_sel_in,
                      force_lim_out_sel_in,
                      ready_sel_in,
                      motion_sel_in,
                      speed_match_sel_in,
                      pos_done_sel_in};  // R8

  assign status_w = {near_position_in,
                     warning_in,
                     brake_release_in,
                     speed_limit_active_in,
                     force_limit_active_in,
                     drive_ready_in,
                     motion_detected_in,
                     speed_match_in,
                     position_done_in};

  assign rt.status  = status_w & status_eval_in;  // R7
  assign rt.out_sel = state_reg.out_sel;  // R10
  assign rt.invert  = state_reg.invert;

  // option inputs four..six have no path from pins 13, 7, 8, 9
  function automatic logic sel_legal(input int idx, input logic [3:0] sel);
    logic restricted;
    logic low_ok;
    logic inv_ok;
    restricted = (idx >= siosm_pkg::IN_OPT4);
    low_ok     = (sel >= siosm_pkg::SEL_OPT_MIN) && (sel <= siosm_pkg::SEL_ALWAYS_OFF);
    inv_ok     = (sel >= siosm_pkg::SEL_OPT_INV_MIN);
    sel_legal  = !restricted || low_ok || inv_ok;  // R3
  endfunction

  function automatic logic in_decode(input logic [3:0] sel, input logic [6:0] pins,
                                     input logic first_high);
    logic [3:0] idx;
    idx = 4'h0;
    if (sel <= siosm_pkg::SEL_PIN_LAST)
    begin
      in_decode = (pins[sel[2:0]] == first_high);  // R1
    end
    else if (sel == siosm_pkg::SEL_ALWAYS_ON)
    begin
      in_decode = 1'b1;  // R2
    end
    else if (sel == siosm_pkg::SEL_ALWAYS_OFF)
    begin
      in_decode = 1'b0;  // R2
    end
    else
    begin
      idx       = sel - siosm_pkg::SEL_INV_BASE;
      in_decode = (pins[idx[2:0]] != first_high);  // R1
    end
  endfunction

  always_comb
  begin
    state_next          = state_reg;
    state_next.pin_meta = conn_in_in;  // R10
    state_next.pin_sync = state_reg.pin_meta;  // R10
    state_next.reject   = 1'b0;
    for (int i = 0; i < siosm_pkg::NUM_IN_FUNCS; i++)
    begin
      // a refused code keeps the last legal setting in force
      if (sel_legal(i, in_sel_w[i]))
      begin
        state_next.in_sel[i] = in_sel_w[i];  // R10
      end
      else
      begin
        state_next.reject = 1'b1;  // R3
      end
    end
    // decode from the registered copy: one edge more, but no glitch on a selector change
    for (int i = 0; i < siosm_pkg::NUM_IN_FUNCS; i++)
    begin
      // every function reads the shared pin vector independently
      state_next.func[i] = in_decode(state_reg.in_sel[i], state_reg.pin_sync,
                                     siosm_pkg::FIRST_LEVEL_HIGH[i]);  // R4
    end
    state_next.out_sel = out_sel_w;  // R10
    state_next.invert  = output_invert_cfg_in;  // R10
    state_next.pair    = rt.pair;  // R6
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      // synchroniser flops cleared too, so no stale pin level follows reset
      state_reg.pin_meta <= '0;
      state_reg.pin_sync <= '0;
      state_reg.func     <= '0;
      state_reg.pair     <= '0;
      state_reg.reject   <= '0;
      state_reg.in_sel   <= {siosm_pkg::NUM_IN_FUNCS{siosm_pkg::IN_SEL_RESET}};
      state_reg.out_sel  <= {siosm_pkg::NUM_OUT_FUNCS{siosm_pkg::OUT_SEL_RESET}};
      state_reg.invert   <= siosm_pkg::INVERT_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // input functions, straight from the state register
  assign fwd_travel_block_out   = state_reg.func[siosm_pkg::IN_FWD_TRAVEL];
  assign rev_travel_block_out   = state_reg.func[siosm_pkg::IN_REV_TRAVEL];
  assign fwd_force_limit_in_out = state_reg.func[siosm_pkg::IN_FWD_FORCE];
  assign rev_force_limit_in_out = state_reg.func[siosm_pkg::IN_REV_FORCE];
  assign option_input_3_out     = state_reg.func[siosm_pkg::IN_OPT3];
  assign option_input_4_out     = state_reg.func[siosm_pkg::IN_OPT4];
  assign option_input_5_out     = state_reg.func[siosm_pkg::IN_OPT5];
  assign option_input_6_out     = state_reg.func[siosm_pkg::IN_OPT6];

  // output pairs and refusal flag
  assign pair_drive_out         = state_reg.pair;
  assign sel_reject_out         = state_reg.reject;

endmodule

// >>> hw/siosm_pkg.sv
package siosm_pkg;

  // connector input pins, index 0..6 = pins 13, 7, 8, 9, 10, 11, 12
  localparam int NUM_PINS      = 7;
  localparam int NUM_IN_FUNCS  = 8;
  localparam int NUM_OUT_FUNCS = 9;
  localparam int NUM_PAIRS     = 3;

  // input function indices
  localparam int IN_FWD_TRAVEL = 0;
  localparam int IN_REV_TRAVEL = 1;
  localparam int IN_FWD_FORCE  = 2;
  localparam int IN_REV_FORCE  = 3;
  localparam int IN_OPT3       = 4;
  localparam int IN_OPT4       = 5;
  localparam int IN_OPT5       = 6;
  localparam int IN_OPT6       = 7;

  // output function indices
  localparam int OUT_POS_DONE    = 0;
  localparam int OUT_SPEED_MATCH = 1;
  localparam int OUT_MOTION      = 2;
  localparam int OUT_READY       = 3;
  localparam int OUT_FORCE_LIM   = 4;
  localparam int OUT_SPEED_LIM   = 5;
  localparam int OUT_BRAKE       = 6;
  localparam int OUT_WARNING     = 7;
  localparam int OUT_NEAR        = 8;

  // input selector codes
  localparam logic [3:0] SEL_PIN_LAST     = 4'h6;
  localparam logic [3:0] SEL_ALWAYS_ON    = 4'h7;
  localparam logic [3:0] SEL_ALWAYS_OFF   = 4'h8;
  localparam logic [3:0] SEL_INV_BASE     = 4'h9;
  localparam logic [3:0] SEL_OPT_MIN      = 4'h4;
  localparam logic [3:0] SEL_OPT_INV_MIN  = 4'hD;

  // first active level per input function, bit set = high
  localparam logic [7:0] FIRST_LEVEL_HIGH = 8'h03;

  // output selector codes: 0 unused, 1..3 pair 1/2, 23/24, 25/26
  localparam logic [1:0] OSEL_NONE = 2'h0;

  // reset values
  localparam logic [3:0] IN_SEL_RESET  = 4'h8;
  localparam logic [1:0] OUT_SEL_RESET = 2'h0;
  localparam logic [2:0] INVERT_RESET  = 3'h0;

endpackage

// >>> hw/siosm_route_if.sv
`timescale 1ns/1ns
interface siosm_route_if;
  logic [8:0]      status;
  logic [8:0][1:0] out_sel;
  logic [2:0]      invert;
  logic [2:0]      pair;

  modport top   (output status, output out_sel, output invert, input pair);
  modport route (input status, input out_sel, input invert, output pair);
endinterface

// >>> hw/siosm_out_route.sv
`timescale 1ns/1ns
module siosm_out_route
(
  siosm_route_if.route rt
);

  // pure combinational; the top registers the result
  always_comb
  begin
    for (int p = 0; p < siosm_pkg::NUM_PAIRS; p++)
    begin
      rt.pair[p] = 1'b0;
      for (int f = 0; f < siosm_pkg::NUM_OUT_FUNCS; f++)
      begin
        if (rt.out_sel[f] == 2'(p + 1))  // R5
        begin
          rt.pair[p] = rt.pair[p] | rt.status[f];  // R6
        end
      end
      // polarity applied after the or so shared pairs invert as one
      rt.pair[p] = rt.pair[p] ^ rt.invert[p];  // R9
    end
  end

endmodule

// >>> testbench/siosm_host_model.sv
`timescale 1ns/1ns
module siosm_host_model
(
  // levels the host wants
  input  wire logic [6:0] level_in,
  // connector input pins
  output logic      [6:0] pin_out
);
  // relay contacts held per test; no bounce modelled, so no sub-cycle pulses
  assign pin_out = level_in;
endmodule

// >>> testbench/siosm_props.sv
`timescale 1ns/1ns
module siosm_props
(
  // clock and reset
  input wire logic       core_clk_in,
  input wire logic       rst_in,
  // inputs
  input wire logic [6:0] conn_in_in,
  input wire logic [3:0] fwd_travel_sel_in,
  input wire logic [3:0] fwd_force_sel_in,
  input wire logic [3:0] rev_force_sel_in,
  input wire logic [3:0] opt_in4_sel_in,
  input wire logic [3:0] opt_in5_sel_in,
  input wire logic [3:0] opt_in6_sel_in,
  input wire logic [1:0] pos_done_sel_in,
  input wire logic [2:0] output_invert_cfg_in,
  input wire logic       position_done_in,
  input wire logic [8:0] status_eval_in,
  // outputs
  input wire logic       fwd_travel_block_out,
  input wire logic       fwd_force_limit_in_out,
  input wire logic       rev_force_limit_in_out,
  input wire logic [2:0] pair_drive_out,
  input wire logic       sel_reject_out
);
  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  function automatic logic ill(input logic [3:0] s);
    return s < 4'h4 || (s > 4'h8 && s < 4'hD);
  endfunction

  // selector held long enough to cover sync and selector latency
  sequence s_pin_sel;
    (fwd_travel_sel_in == 4'h0)[*4];
  endsequence
  sequence s_route0;
    (pos_done_sel_in == 2'h1 && !output_invert_cfg_in[0])[*3];
  endsequence

  a_pin_direct: assert property (s_pin_sel |->
    fwd_travel_block_out == $past(conn_in_in[0], 3)) else $error("direct pin wrong");
  a_pin_inverted: assert property ((rev_force_sel_in == 4'h9)[*4] |->
    rev_force_limit_in_out == $past(conn_in_in[0], 3)) else $error("inverted pin wrong");
  a_force_on: assert property ((fwd_force_sel_in == 4'h7)[*3] |->
    fwd_force_limit_in_out) else $error("always on lost");
  a_reject_flag: assert property (ill(opt_in4_sel_in) || ill(opt_in5_sel_in) ||
    ill(opt_in6_sel_in) |=> sel_reject_out) else $error("refusal not flagged");
  a_accept_clear: assert property (!ill(opt_in4_sel_in) && !ill(opt_in5_sel_in) &&
    !ill(opt_in6_sel_in) |=> !sel_reject_out) else $error("false refusal");
  a_pair_route: assert property (s_route0 ##0
    $past(position_done_in && status_eval_in[0]) |-> pair_drive_out[0]) else $error("route lost");
  a_mode_mask: assert property ((status_eval_in == 9'h0 && output_invert_cfg_in == 3'h0)[*3]
    |-> pair_drive_out == 3'h0) else $error("unevaluated status drove pair");
  a_pair_invert: assert property ((status_eval_in == 9'h0 && output_invert_cfg_in == 3'h7)[*3]
    |-> pair_drive_out == 3'h7) else $error("invert not applied");
endmodule

bind siosm_top siosm_props u_props
(
  .core_clk_in            (core_clk_in),
  .rst_in                 (rst_in),
  .conn_in_in             (conn_in_in),
  .fwd_travel_sel_in      (fwd_travel_sel_in),
  .fwd_force_sel_in       (fwd_force_sel_in),
  .rev_force_sel_in       (rev_force_sel_in),
  .opt_in4_sel_in         (opt_in4_sel_in),
  .opt_in5_sel_in         (opt_in5_sel_in),
  .opt_in6_sel_in         (opt_in6_sel_in),
  .pos_done_sel_in        (pos_done_sel_in),
  .output_invert_cfg_in   (output_invert_cfg_in),
  .position_done_in       (position_done_in),
  .status_eval_in         (status_eval_in),
  .fwd_travel_block_out   (fwd_travel_block_out),
  .fwd_force_limit_in_out (fwd_force_limit_in_out),
  .rev_force_limit_in_out (rev_force_limit_in_out),
  .pair_drive_out         (pair_drive_out),
  .sel_reject_out         (sel_reject_out)
);

// >>> testbench/siosm_top_tb_top.sv
`timescale 1ns/1ns
module siosm_top_tb_top;
  logic        core_clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [6:0]  level;
  logic [6:0]  conn_in_in;
  logic [3:0]  isel[8], esel[8];
  logic [1:0]  osel[9];
  logic [8:0]  st, status_eval_in;
  logic [2:0]  output_invert_cfg_in;
  logic [31:0] seed = 32'h8533158E;
  logic [3:0]  okv[8] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hD, 4'hE, 4'hF};
  logic [3:0]  badv[8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h9, 4'hA, 4'hB, 4'hC};
  int          bad_count = 0, compares = 0;
  wire [3:0] fwd_travel_sel_in = isel[0], rev_travel_sel_in = isel[1], fwd_force_sel_in = isel[2],
    rev_force_sel_in = isel[3], opt_in3_sel_in = isel[4], opt_in4_sel_in = isel[5],
    opt_in5_sel_in = isel[6], opt_in6_sel_in = isel[7];
  wire [1:0] pos_done_sel_in = osel[0], speed_match_sel_in = osel[1], motion_sel_in = osel[2],
    ready_sel_in = osel[3], force_lim_out_sel_in = osel[4], speed_lim_out_sel_in = osel[5],
    brake_sel_in = osel[6], warning_sel_in = osel[7], near_sel_in = osel[8];
  wire position_done_in = st[0], speed_match_in = st[1], motion_detected_in = st[2],
    drive_ready_in = st[3], force_limit_active_in = st[4], speed_limit_active_in = st[5],
    brake_release_in = st[6], warning_in = st[7], near_position_in = st[8];
  wire fwd_travel_block_out, rev_travel_block_out, fwd_force_limit_in_out, rev_force_limit_in_out,
    option_input_3_out, option_input_4_out, option_input_5_out, option_input_6_out, sel_reject_out;
  wire [2:0] pair_drive_out;
  wire [7:0] fo = {option_input_6_out, option_input_5_out, option_input_4_out, option_input_3_out,
    rev_force_limit_in_out, fwd_force_limit_in_out, rev_travel_block_out, fwd_travel_block_out};

  siosm_top uut (.*);
  siosm_host_model host (.level_in(level), .pin_out(conn_in_in));

  always #25 core_clk_in = ~core_clk_in;

  function logic [31:0] nxt();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // first level is high only for the two travel blocks
  function logic efn(int f, logic [3:0] s);
    if (s == 4'h7) return 1'b1;
    if (s == 4'h8) return 1'b0;
    if (s < 4'h7) return level[s] == (f < 2);
    return level[s - 4'h9] != (f < 2);
  endfunction

  function logic [2:0] epair();
    logic [2:0] p;
    p = 3'h0;
    for (int k = 0; k < 9; k++)
      if (st[k] && status_eval_in[k] && osel[k] != 2'h0) p[osel[k] - 2'h1] = 1'b1;
    return p ^ output_invert_cfg_in;
  endfunction

  task check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task report_and_stop();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task settle(input logic rej);
    logic [7:0] e;
    repeat (4) @(negedge core_clk_in);
    for (int f = 0; f < 8; f++) e[f] = efn(f, esel[f]);
    check(16'(fo), 16'(e));
    check(16'(pair_drive_out), 16'(epair()));
    check(16'(sel_reject_out), 16'(rej));
  endtask

  task shuffle();
    logic [31:0] r;
    for (int i = 0; i < 9; i++)
    begin
      r = nxt();
      osel[i] = r[5:4];
      if (i < 8) isel[i] = (i < 5) ? r[3:0] : okv[r[2:0]];
      if (i < 8) esel[i] = isel[i];
    end
    r = nxt();
    level = r[6:0];
    st = r[15:7];
    status_eval_in = r[24:16];
    output_invert_cfg_in = r[27:25];
  endtask

  initial
  begin
    level = 7'h0;
    st = 9'h0;
    status_eval_in = 9'h0;
    output_invert_cfg_in = 3'h0;
    foreach (isel[i]) isel[i] = 4'h8;
    esel = isel;
    foreach (osel[k]) osel[k] = 2'h0;
    repeat (3) @(posedge core_clk_in);
    @(negedge core_clk_in);
    check(16'({fo, pair_drive_out, sel_reject_out}), 16'h0);
    rst_in = 1'b0;
    $display("reset test done");
    repeat (300)
    begin
      shuffle();
      settle(1'b0);
    end
    $display("random test done");
    for (int m = 0; m < 2; m++)
    begin
      shuffle();
      status_eval_in = 9'h0;
      output_invert_cfg_in = {3{m[0]}};
      settle(1'b0);
    end
    $display("mask test done");
    for (int b = 0; b < 8; b++)
    begin
      shuffle();
      settle(1'b0);
      isel[5 + b % 3] = badv[b];
      settle(1'b1);
    end
    $display("refuse test done");
    shuffle();
    rst_in = 1'b1;
    repeat (2) @(negedge core_clk_in);
    check(16'({fo, pair_drive_out, sel_reject_out}), 16'h0);
    rst_in = 1'b0;
    settle(1'b0);
    $display("mid reset test done");
    report_and_stop();
  end

  initial
  begin
    #(50 * 4000);
    bad_count++;
    report_and_stop();
  end
endmodule
